// file: cps_pkg.sv
// Constants, register map and carrier types of the charger power-up sequencer.
// Assumes a 125 MHz clock and comparator and ADC results synchronous to it.
package cps_pkg;

	// ----------------------------------------
	// Timebase
	// ----------------------------------------
	localparam int CLK_MHZ       = 125;
	localparam int TICK_NS       = 1000;
	localparam int CLK_PER_TICK  = TICK_NS * CLK_MHZ / 1000;
	localparam int TICK_PER_MS   = 1000000 / TICK_NS;
	localparam int T_POR_MS      = 5;
	localparam int T_ACCESS_MS   = 20;
	localparam int T_BIAS_MS     = 150;
	localparam int T_QUAL_MS     = 30;
	localparam int T_START_MS    = 30;
	localparam int T_RETRY_MIN   = 7;
	localparam int T_ALERT_NS    = 256;
	localparam int POR_TICKS     = T_POR_MS * TICK_PER_MS;
	localparam int ACCESS_TICKS  = T_ACCESS_MS * TICK_PER_MS;
	localparam int BIAS_TICKS    = T_BIAS_MS * TICK_PER_MS;
	localparam int QUAL_TICKS    = T_QUAL_MS * TICK_PER_MS;
	localparam int START_TICKS   = T_START_MS * TICK_PER_MS;
	localparam int RETRY_TICKS   = T_RETRY_MIN * 60 * 1000 * TICK_PER_MS;
	localparam int ALERT_CYC     = (T_ALERT_NS * CLK_MHZ + 999) / 1000;

	// ----------------------------------------
	// Analog thresholds and setting codes
	// ----------------------------------------
	localparam int LIMIT_STOP_MV   = 750;
	localparam int LIMIT_RESUME_MV = 1000;
	localparam int CLAMP_OFFSET_MV = 1000;
	localparam int CLAMP_MIN_MV    = 1080;
	localparam int CLAMP_R_MOHM    = 800;
	localparam int ILIM_LSB_MA     = 10;
	localparam logic [8:0] ILIM_MIN = 9'h00A;
	localparam logic [8:0] ILIM_POR = 9'h12C;
	localparam logic [8:0] ILIM_MAX = 9'h1FF;
	localparam int VBUS_HI_MV      = 7000;
	localparam int DROP_HI_MV      = 1400;
	localparam int DROP_LO_MV      = 700;
	localparam int VLIM_LSB_MV     = 100;
	localparam logic [7:0] VLIM_MIN = 8'h24;
	localparam logic [7:0] VLIM_MAX = 8'hDC;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [7:0] ADDR_STATUS = 8'h00;
	localparam logic [7:0] ADDR_FLAG   = 8'h04;
	localparam logic [7:0] ADDR_MASK   = 8'h08;
	localparam logic [7:0] ADDR_CTRL   = 8'h0C;
	localparam logic [7:0] ADDR_ILIM   = 8'h10;
	localparam logic [7:0] ADDR_VLIM   = 8'h14;
	localparam logic [7:0] ADDR_CONFIG = 8'h18;
	localparam int BIT_PG   = 0;
	localparam int BIT_OV   = 1;
	localparam int BIT_DONE = 2;
	localparam int BIT_HIZ  = 0;
	localparam int BIT_EXTL = 1;
	localparam int BIT_AUTO = 2;
	localparam int BIT_FRC  = 3;
	localparam int BIT_THRM = 4;
	localparam int BIT_CONV = 5;
	localparam int BIT_OTG  = 6;
	localparam logic [6:0] CTRL_RESET = 7'h26;

	typedef enum logic [10:0] {
		ST_IDLE    = 11'h001,
		ST_BATTERY = 11'h002,
		ST_BIAS    = 11'h004,
		ST_QUALIFY = 11'h008,
		ST_OVERV   = 11'h010,
		ST_RETRY   = 11'h020,
		ST_DETECT  = 11'h040,
		ST_MEASURE = 11'h080,
		ST_START   = 11'h100,
		ST_RUN     = 11'h200,
		ST_REMEAS  = 11'h400
	} cps_state_t;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [7:0]  addr;
		logic [31:0] wdata;
	} cps_bus_t;

	typedef struct packed {
		logic        batUvloOk;
		logic        busUvloOk;
		logic        directPath;
		logic        auxPresent;
		logic        busOverVolt;
		logic        busPoor;
		logic        batAbove3v2;
		logic        sysMinStatus;
		logic        pairDetected;
		logic [2:0]  configCode;
		logic [11:0] limitPinMv;
		logic [14:0] busMv;
	} cps_sense_t;

endpackage

// file: cps_power_up_sequencer.sv
// Charger power-up sequencer: supply qualification, limits, alert pin, registers.
// Assumes sense inputs are synchronous to clk; source-type detection is external.
//
// Contract
// - Battery only: bias off, battery switch on
// - Start on bus release or aux presence
// - 5 ms: detect pair, read config, load
// - Detected input pair gets its gate driven
// - Registers open 20 ms after supply
// - Bus present sets status; bias 150 ms later
// - Qualify 30 ms; pass sets good, alerts
// - After qualifying, detect source, update type, limit
// - Start switching 30 ms after detection
// - Battery-only bias on via OTG, or above 3.2V with conversion on and thermistor bit clear
// - Overvoltage: status, flag, alert, auto retry
// - Poor source: high impedance, flag, alert
// - Retry qualification every 7 minutes
// - Insertion clears high impedance; clear retries
// - Clamp from limit pin: 1V plus 0.8 ohm
// - Current limit held at clamp; reject higher
// - Limit pin below 0.75V stops, 1V resumes
// - Pin below 1.08V means 100mA clamp
// - Voltage limit: bus minus 1.4V or 0.7V
// - Forced remeasure, skipped at system minimum
// - Voltage limit saturates to 3.6V, 22V
// - Detection done: status, flag, masked alert
// - Config pin picks frequency and cell count
//
// Added by the designer: strobed register access and the address map.
`timescale 1ns/1ps

module cps_power_up_sequencer
	import cps_pkg::*;
#(
	parameter int POR_T    = POR_TICKS,
	parameter int ACCESS_T = ACCESS_TICKS,
	parameter int BIAS_T   = BIAS_TICKS,
	parameter int QUAL_T   = QUAL_TICKS,
	parameter int START_T  = START_TICKS,
	parameter int RETRY_T  = RETRY_TICKS
)
(
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire cps_bus_t    busReq,
	output logic [31:0]      rdData,
	input  wire cps_sense_t  sense,
	input  wire logic        detectDone,
	input  wire logic [3:0]  detectType,
	input  wire logic [8:0]  detectLimit,
	output logic             detectActive,
	output logic             biasOn,
	output logic             batterySwitchOn,
	output logic             pairGateOn,
	output logic             switching,
	input  wire logic        alertIn,
	output logic             alertOut,
	output logic             alertOeN
);

	// ----------------------------------------
	// Parameter checks
	// ----------------------------------------
	if (POR_T < 1 || ACCESS_T <= POR_T || BIAS_T < 1 || QUAL_T < 1 || START_T < 1 || RETRY_T < 1)
		$error("cps_power_up_sequencer: bad timing parameters");

	// ----------------------------------------
	// Functions
	// ----------------------------------------
	function automatic logic [8:0] clampFromPin(input logic [11:0] mv);
		int code;
		code = (int'(mv) - CLAMP_OFFSET_MV) * 1000 / (CLAMP_R_MOHM * ILIM_LSB_MA);
		if (int'(mv) < CLAMP_MIN_MV)
			return ILIM_MIN;
		if (code > int'(ILIM_MAX))
			return ILIM_MAX;
		return 9'(code);
	endfunction

	function automatic logic [7:0] vlimFromBus(input logic [14:0] mv);
		int drop;
		int code;
		drop = (int'(mv) >= VBUS_HI_MV) ? DROP_HI_MV : DROP_LO_MV;
		code = (int'(mv) - drop) / VLIM_LSB_MV;
		if (code < int'(VLIM_MIN))
			return VLIM_MIN;
		if (code > int'(VLIM_MAX))
			return VLIM_MAX;
		return 8'(code);
	endfunction

	// ----------------------------------------
	// Timebase and supply timer
	// ----------------------------------------
	logic [6:0]  divCnt;
	logic [31:0] supplyTimer;
	logic [31:0] stateTimer;
	logic        porDone;
	wire         tick        = (int'(divCnt) == CLK_PER_TICK - 1);
	wire         busValid    = sense.directPath ? sense.busUvloOk : sense.auxPresent;
	wire         supplyValid = sense.batUvloOk | busValid;
	wire         porHit      = supplyValid & !porDone & (int'(supplyTimer) >= POR_T);
	wire         regsOpen    = int'(supplyTimer) >= ACCESS_T;

	always_ff @(posedge clk)
	begin
		if (reset || tick)
			divCnt <= 7'h00;
		else
			divCnt <= divCnt + 7'h01;
	end

	always_ff @(posedge clk)
	begin
		if (reset || !supplyValid)
			supplyTimer <= 32'h00000000;
		else if (tick && int'(supplyTimer) < ACCESS_T)
			supplyTimer <= supplyTimer + 32'h00000001;
	end

	// ----------------------------------------
	// Power-on configuration capture
	// ----------------------------------------
	logic       pairFound;
	logic       freqSel;
	logic [1:0] cellCount;

	always_ff @(posedge clk)
	begin
		if (reset || !supplyValid)
		begin
			porDone   <= 1'b0;
			pairFound <= 1'b0;
			freqSel   <= 1'b0;
			cellCount <= 2'h0;
		end
		else if (porHit)
		begin
			porDone   <= 1'b1;
			pairFound <= sense.pairDetected;
			freqSel   <= sense.configCode[0];
			cellCount <= sense.configCode[2:1];
		end
	end

	// ----------------------------------------
	// Register state
	// ----------------------------------------
	logic [6:0] ctrl;
	logic [2:0] flags;
	logic [2:0] mask;
	logic [8:0] ilim;
	logic [8:0] clamp;
	logic [7:0] vlim;
	logic [3:0] sourceType;
	logic       doneStatus;
	logic       busPrev;
	logic       limitStop;
	cps_state_t state;
	cps_state_t next_state;

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	wire isQual   = state == ST_QUALIFY;
	wire ovEnter  = isQual & sense.busOverVolt;
	wire qualFail = isQual & !sense.busOverVolt & sense.busPoor;
	wire qualPass = isQual & !sense.busOverVolt & !sense.busPoor & (int'(stateTimer) >= QUAL_T);
	wire detFinish = (state == ST_DETECT) & detectDone;
	wire bootBias = ctrl[BIT_OTG] | (sense.batAbove3v2 & ctrl[BIT_CONV] & !ctrl[BIT_THRM]);

	always_comb
	begin
		next_state = state;
		if (!porDone)
			next_state = ST_IDLE;
		else if (!sense.busUvloOk)
			next_state = ST_BATTERY;
		else
			case (state)
				ST_IDLE, ST_BATTERY:
					next_state = ST_BIAS;
				ST_BIAS:
					if (int'(stateTimer) >= BIAS_T)
						next_state = ST_QUALIFY;
				ST_QUALIFY:
					if (ovEnter)
						next_state = ST_OVERV;
					else if (qualFail)
						next_state = ST_RETRY;
					else if (qualPass)
						next_state = ctrl[BIT_AUTO] ? ST_DETECT : ST_MEASURE;
				ST_OVERV:
					if (!sense.busOverVolt)
						next_state = ST_QUALIFY;
				ST_RETRY:
					if (!ctrl[BIT_HIZ] || int'(stateTimer) >= RETRY_T)
						next_state = ST_QUALIFY;
				ST_DETECT:
					if (detectDone)
						next_state = ST_MEASURE;
				ST_MEASURE:
					next_state = ST_START;
				ST_START:
					if (int'(stateTimer) >= START_T)
						next_state = ST_RUN;
				ST_RUN:
					if (ctrl[BIT_FRC] && !sense.sysMinStatus)
						next_state = ST_REMEAS;
				ST_REMEAS:
					next_state = ST_RUN;
				default:
					next_state = ST_IDLE;
			endcase
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			state <= ST_IDLE;
		else
			state <= next_state;
	end

	always_ff @(posedge clk)
	begin
		if (reset || next_state != state)
			stateTimer <= 32'h00000000;
		else if (tick)
			stateTimer <= stateTimer + 32'h00000001;
	end

	// ----------------------------------------
	// Power path outputs
	// ----------------------------------------
	wire postQual = |(next_state & (ST_DETECT | ST_MEASURE | ST_START | ST_RUN | ST_REMEAS));
	wire busBias  = |(next_state & (ST_QUALIFY | ST_OVERV | ST_RETRY)) | postQual;

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			biasOn          <= 1'b0;
			batterySwitchOn <= 1'b0;
			pairGateOn      <= 1'b0;
			switching       <= 1'b0;
			detectActive    <= 1'b0;
			limitStop       <= 1'b0;
		end
		else
		begin
			biasOn          <= busBias | (next_state == ST_BATTERY && bootBias);
			batterySwitchOn <= porDone & sense.batUvloOk;
			pairGateOn      <= pairFound & busValid;
			switching       <= (next_state == ST_RUN) & !limitStop & !ctrl[BIT_HIZ] & ctrl[BIT_CONV];
			detectActive    <= next_state == ST_DETECT;
			if (int'(sense.limitPinMv) < LIMIT_STOP_MV)
				limitStop <= 1'b1;
			else if (int'(sense.limitPinMv) > LIMIT_RESUME_MV)
				limitStop <= 1'b0;
		end
	end

	// ----------------------------------------
	// Register bus decode
	// ----------------------------------------
	wire        wrOk    = busReq.wr & regsOpen;
	wire        wrFlag  = wrOk & (busReq.addr == ADDR_FLAG);
	wire        wrMask  = wrOk & (busReq.addr == ADDR_MASK);
	wire        wrCtrl  = wrOk & (busReq.addr == ADDR_CTRL);
	wire [8:0]  wrIlimV = busReq.wdata[8:0];
	wire        wrIlim  = wrOk & (busReq.addr == ADDR_ILIM) & (!ctrl[BIT_EXTL] | wrIlimV <= clamp);
	wire        insert  = sense.busUvloOk & !busPrev;
	wire [8:0]  newClamp = clampFromPin(sense.limitPinMv);
	wire [2:0]  flagSet = {detFinish, ovEnter, qualPass | qualFail};
	wire [31:0] statusWord = {20'h00000, sourceType, switching, biasOn, regsOpen, doneStatus,
		state == ST_OVERV, postQual & (state != ST_IDLE), sense.sysMinStatus, sense.busUvloOk};
	wire [31:0] readMux =
		(busReq.addr == ADDR_STATUS) ? statusWord :
		(busReq.addr == ADDR_FLAG)   ? {29'h00000000, flags} :
		(busReq.addr == ADDR_MASK)   ? {29'h00000000, mask} :
		(busReq.addr == ADDR_CTRL)   ? {25'h0000000, ctrl} :
		(busReq.addr == ADDR_ILIM)   ? {23'h000000, ilim} :
		(busReq.addr == ADDR_VLIM)   ? {24'h000000, vlim} :
		(busReq.addr == ADDR_CONFIG) ? {15'h0000, clamp, 4'h0, pairFound, cellCount, freqSel} :
		32'h00000000;

	always_ff @(posedge clk)
	begin
		if (reset)
			rdData <= 32'h00000000;
		else
			rdData <= (busReq.rd && regsOpen) ? readMux : 32'h00000000;
	end

	// ----------------------------------------
	// Control, flags and masks
	// ----------------------------------------
	always_ff @(posedge clk)
	begin
		if (reset || !porDone)
		begin
			ctrl  <= CTRL_RESET;
			flags <= 3'h0;
			mask  <= 3'h0;
		end
		else
		begin
			if (wrCtrl)
				ctrl <= busReq.wdata[6:0];
			if (insert)
				ctrl[BIT_HIZ] <= 1'b0;
			if (qualFail)
				ctrl[BIT_HIZ] <= 1'b1;
			if ((state == ST_RUN && sense.sysMinStatus) || state == ST_REMEAS)
				ctrl[BIT_FRC] <= 1'b0;
			if (wrMask)
				mask <= busReq.wdata[2:0];
			flags <= (flags & ~(wrFlag ? busReq.wdata[2:0] : 3'h0)) | flagSet;
		end
	end

	// ----------------------------------------
	// Limits and detection results
	// ----------------------------------------
	always_ff @(posedge clk)
	begin
		if (reset || !porDone)
		begin
			ilim       <= ILIM_POR;
			clamp      <= ILIM_MAX;
			vlim       <= VLIM_MIN;
			sourceType <= 4'h0;
			doneStatus <= 1'b0;
			busPrev    <= 1'b0;
		end
		else
		begin
			busPrev <= sense.busUvloOk;
			if (qualPass)
			begin
				clamp <= newClamp;
				ilim  <= (ilim > newClamp) ? newClamp : ilim;
				vlim  <= vlimFromBus(sense.busMv);
			end
			else if (detFinish)
				ilim <= (detectLimit > clamp) ? clamp : detectLimit;
			else if (wrIlim)
				ilim <= wrIlimV;
			if (state == ST_MEASURE || state == ST_REMEAS)
				vlim <= vlimFromBus(sense.busMv);
			if (detFinish)
			begin
				sourceType <= detectType;
				doneStatus <= 1'b1;
			end
			else if (!sense.busUvloOk)
			begin
				sourceType <= 4'h0;
				doneStatus <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Alert pulse
	// ----------------------------------------
	logic [7:0] alertCnt;
	wire alertFire = ((qualPass | qualFail) & !mask[BIT_PG])
		| (ovEnter & (!mask[BIT_OV] | !mask[BIT_PG]))
		| (detFinish & !mask[BIT_DONE]);

	always_ff @(posedge clk)
	begin
		if (reset)
			alertCnt <= 8'h00;
		else if (alertFire)
			alertCnt <= 8'(ALERT_CYC);
		else if (alertCnt != 8'h00)
			alertCnt <= alertCnt - 8'h01;
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			alertOeN <= 1'b1;
		else
			alertOeN <= (alertCnt == 8'h00);
	end

	assign alertOut = 1'b0;

endmodule

// file: cps_power_up_sequencer_assertions.sv
// Port checker for the charger power-up sequencer, bound to its top module.
// Assumes one clock domain and the synchronous active-high reset.
`timescale 1ns/1ps

module cps_port_chk
	import cps_pkg::*;
#(
	parameter int BIAS_T  = BIAS_TICKS,
	parameter int START_T = START_TICKS
)
(
	input wire logic        clk,
	input wire logic        reset,
	input wire cps_bus_t    busReq,
	input wire logic [31:0] rdData,
	input wire cps_sense_t  sense,
	input wire logic        detectDone,
	input wire logic        detectActive,
	input wire logic        biasOn,
	input wire logic        switching,
	input wire logic        alertOut,
	input wire logic        alertOeN
);
	int lowCnt;
	int busCnt;
	int detCnt;

	// ----------------------------------------
	// Cycle counters
	// ----------------------------------------
	always_ff @(posedge clk)
	begin
		lowCnt <= alertOeN ? 0 : lowCnt + 1;
		busCnt <= (sense.busUvloOk && !reset) ? busCnt + 1 : 0;
		detCnt <= detectActive ? 0 : detCnt + 1;
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	// ----------------------------------------
	// Properties
	// ----------------------------------------
	AST_ALERT_LOW: assert property (!alertOeN |-> alertOut == 1'b0)
		else $error("alert pin driven high");
	AST_ALERT_WIDTH: assert property ($rose(alertOeN) |-> lowCnt >= ALERT_CYC)
		else $error("alert pulse too short");
	AST_BIAS_WAIT: assert property ($rose(biasOn) && sense.busUvloOk |-> busCnt >= (BIAS_T - 1) * CLK_PER_TICK)
		else $error("bias on too early");
	AST_SWITCH_BIAS: assert property (switching |-> biasOn)
		else $error("switching without bias");
	AST_LIMIT_STOP: assert property (sense.limitPinMv < LIMIT_STOP_MV |-> ##[1:3] !switching)
		else $error("switching with limit pin low");
	AST_BUS_LOSS: assert property (!sense.busUvloOk |-> ##[1:3] (!switching && !detectActive))
		else $error("activity without bus");
	AST_DETECT_END: assert property (detectDone && detectActive |-> ##[1:3] !detectActive)
		else $error("detection not ended");
	AST_START_DELAY: assert property ($rose(switching) |-> detCnt >= (START_T - 1) * CLK_PER_TICK)
		else $error("switching too early");
	AST_RD_IDLE: assert property (!busReq.rd |=> rdData == 32'h0)
		else $error("read data without read");

	cover property ($fell(alertOeN));
	cover property (detectDone && detectActive);
	cover property ($rose(switching));
endmodule

bind cps_power_up_sequencer cps_port_chk #(
	.BIAS_T  (BIAS_T),
	.START_T (START_T)
) i_cps_port_chk (
	.clk          (clk),
	.reset        (reset),
	.busReq       (busReq),
	.rdData       (rdData),
	.sense        (sense),
	.detectDone   (detectDone),
	.detectActive (detectActive),
	.biasOn       (biasOn),
	.switching    (switching),
	.alertOut     (alertOut),
	.alertOeN     (alertOeN)
);

// file: cps_detect_partner.sv
// Behavioural source-type detector and alert pull-up beside the sequencer.
// Assumes detectActive is a registered level from the sequencer.
`timescale 1ns/1ps

module cps_detect_partner
	import cps_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       reset,
	input  wire logic       detectActive,
	input  wire logic [7:0] answerDelay,
	input  wire logic [3:0] typeCode,
	input  wire logic [8:0] limitCode,
	input  wire logic       alertOut,
	input  wire logic       alertOeN,
	output logic            detectDone,
	output logic [3:0]      detectType,
	output logic [8:0]      detectLimit,
	output logic            alertIn,
	output logic [7:0]      alertPulses
);
	logic [7:0] waitCnt;
	logic [8:0] noise = 9'h000;
	logic       alertPrev;

	// ----------------------------------------
	// Pin level and answer
	// ----------------------------------------
	assign alertIn     = alertOeN ? 1'b1 : alertOut;
	assign detectType  = detectDone ? typeCode : noise[3:0];
	assign detectLimit = detectDone ? limitCode : noise;

	always_ff @(posedge clk)
	begin
		noise     <= noise + 9'h0B5;
		alertPrev <= alertIn;
		if (reset)
		begin
			waitCnt     <= 8'h00;
			detectDone  <= 1'b0;
			alertPulses <= 8'h00;
		end
		else
		begin
			detectDone <= detectActive && !detectDone && waitCnt == answerDelay;
			waitCnt    <= (detectActive && waitCnt != answerDelay) ? waitCnt + 8'h01 : 8'h00;
			if (alertPrev && !alertIn)
				alertPulses <= alertPulses + 8'h01;
		end
	end
endmodule

// file: cps_power_up_sequencer_tb_top.sv
// Directed tests of the power-up sequencer through its register port.
// Assumes the detection partner model and the bound port checker.
`timescale 1ns/1ps

module cps_power_up_sequencer_tb_top
	import cps_pkg::*;
;
	localparam logic [31:0] FULL = 32'hFFFFFFFF;
	logic        clk = 1'b0;
	logic        reset = 1'b1;
	cps_bus_t    busReq = '0;
	cps_sense_t  sense;
	logic [31:0] rdData;
	logic [31:0] v;
	logic        detectDone, detectActive, biasOn, batterySwitchOn, pairGateOn, switching;
	logic        alertIn, alertOut, alertOeN;
	logic [3:0]  detectType;
	logic [8:0]  detectLimit;
	logic [7:0]  answerDelay, alertPulses, n0;
	logic [3:0]  typeCode;
	logic [8:0]  limitCode;
	logic [14:0] mvTab [3] = '{15'h1388, 15'h7530, 15'h0BB8};
	logic [31:0] vlTab [3] = '{32'h2B, 32'hDC, 32'h24};
	logic [6:0]  ctlTab [6] = '{7'h26, 7'h26, 7'h36, 7'h06, 7'h66, 7'h26};
	logic [5:0]  b32Bits = 6'h0E;
	logic [5:0]  biasBits = 6'h12;
	int          errorCnt = 0;
	int          testsRun = 0;

	always #4 clk = ~clk;

	cps_power_up_sequencer #(.POR_T(2), .ACCESS_T(4), .BIAS_T(3), .QUAL_T(3), .START_T(3), .RETRY_T(5))
	i_cps_power_up_sequencer (.clk(clk), .reset(reset), .busReq(busReq), .rdData(rdData), .sense(sense),
		.detectDone(detectDone), .detectType(detectType), .detectLimit(detectLimit),
		.detectActive(detectActive), .biasOn(biasOn), .batterySwitchOn(batterySwitchOn),
		.pairGateOn(pairGateOn), .switching(switching), .alertIn(alertIn), .alertOut(alertOut),
		.alertOeN(alertOeN));

	cps_detect_partner i_cps_detect_partner (.clk(clk), .reset(reset), .detectActive(detectActive),
		.answerDelay(answerDelay), .typeCode(typeCode), .limitCode(limitCode), .alertOut(alertOut),
		.alertOeN(alertOeN), .detectDone(detectDone), .detectType(detectType),
		.detectLimit(detectLimit), .alertIn(alertIn), .alertPulses(alertPulses));

	// ----------------------------------------
	// Bus and compare tasks
	// ----------------------------------------
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		testsRun++;
		if (g !== e)
		begin
			errorCnt++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic chkPin(input string n, input logic e, input logic g);
		chk(n, {31'h0, e}, {31'h0, g});
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		busReq <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clk);
		busReq <= '0;
		@(posedge clk);
	endtask

	task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input int lim,
		input string n);
		for (int i = 0; i < lim; i++)
		begin
			busReq <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
			@(posedge clk);
			busReq <= '0;
			@(negedge clk);
			v = rdData;
			@(posedge clk);
			if ((v & m) === e)
				break;
		end
		chk(n, e, v & m);
	endtask

	task automatic completeRun();
		$display("Comparisons %0d, mismatches %0d", testsRun, errorCnt);
		if (errorCnt == 0 && testsRun > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	initial
	begin
		repeat (40000) @(posedge clk);
		errorCnt++;
		completeRun();
	end

	// ----------------------------------------
	// Test sequence
	// ----------------------------------------
	initial
	begin
		sense <= '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 3'h5, 12'h708, 15'h2328};
		answerDelay <= 8'h3C;
		typeCode <= 4'h3;
		limitCode <= 9'h145;
		repeat (4) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		poll(ADDR_STATUS, FULL, 32'h0, 1, "early status");
		wr(ADDR_MASK, 32'h7);
		poll(ADDR_STATUS, 32'h20, 32'h20, 400, "open");
		poll(ADDR_MASK, FULL, 32'h0, 1, "mask");
		poll(ADDR_CTRL, FULL, 32'h26, 1, "ctrl");
		chkPin("pair gate", 1'b1, pairGateOn);
		poll(ADDR_STATUS, 32'h41, 32'h41, 400, "bias");
		poll(ADDR_STATUS, 32'hFFF, 32'h3F5, 2000, "running");
		poll(ADDR_CONFIG, FULL, 32'h640D, 1, "config");
		poll(ADDR_FLAG, FULL, 32'h5, 1, "flags");
		poll(ADDR_ILIM, FULL, 32'h64, 1, "ilim");
		poll(ADDR_VLIM, FULL, 32'h4C, 1, "vlim");
		chk("alerts", 32'h2, {24'h0, alertPulses});
		$display("Test power up done");
		wr(ADDR_ILIM, 32'hC8);
		poll(ADDR_ILIM, FULL, 32'h64, 1, "over clamp");
		wr(ADDR_ILIM, 32'h50);
		poll(ADDR_ILIM, FULL, 32'h50, 1, "under clamp");
		wr(ADDR_CTRL, 32'h24);
		wr(ADDR_ILIM, 32'hC8);
		poll(ADDR_ILIM, FULL, 32'hC8, 1, "no clamp");
		wr(ADDR_CTRL, 32'h26);
		wr(ADDR_VLIM, 32'h11);
		poll(ADDR_VLIM, FULL, 32'h4C, 1, "vlim ro");
		poll(8'h1C, FULL, 32'h0, 1, "unmapped");
		$display("Test registers done");
		sense.limitPinMv <= 12'h2BC;
		repeat (4) @(posedge clk);
		chkPin("stop", 1'b0, switching);
		chkPin("bias kept", 1'b1, biasOn);
		sense.limitPinMv <= 12'h384;
		repeat (4) @(posedge clk);
		chkPin("hysteresis", 1'b0, switching);
		sense.limitPinMv <= 12'h44C;
		poll(ADDR_STATUS, 32'h80, 32'h80, 4, "resume");
		for (int k = 0; k < 3; k++)
		begin
			sense.busMv <= mvTab[k];
			wr(ADDR_CTRL, 32'h2E);
			poll(ADDR_CTRL, 32'h8, 32'h0, 20, "force clears");
			poll(ADDR_VLIM, FULL, vlTab[k], 1, "remeasure");
		end
		sense.sysMinStatus <= 1'b1;
		@(posedge clk);
		sense.busMv <= 15'h2328;
		wr(ADDR_CTRL, 32'h2E);
		poll(ADDR_CTRL, 32'h8, 32'h0, 20, "force skipped");
		poll(ADDR_VLIM, FULL, 32'h24, 1, "vlim kept");
		sense.sysMinStatus <= 1'b0;
		$display("Test limits done");
		wr(ADDR_MASK, 32'h2);
		wr(ADDR_FLAG, 32'h7);
		answerDelay <= 8'h03;
		typeCode <= 4'h1;
		limitCode <= 9'h032;
		n0 = alertPulses;
		sense.busUvloOk <= 1'b0;
		sense.busOverVolt <= 1'b1;
		sense.limitPinMv <= 12'h41A;
		repeat (4) @(posedge clk);
		sense.busUvloOk <= 1'b1;
		poll(ADDR_STATUS, 32'h8C, 32'h08, 400, "overvoltage");
		poll(ADDR_FLAG, 32'h2, 32'h2, 1, "ov flag");
		chk("ov alert", {24'h0, n0 + 8'h01}, {24'h0, alertPulses});
		sense.busOverVolt <= 1'b0;
		poll(ADDR_STATUS, 32'hF8C, 32'h184, 2000, "requalified");
		poll(ADDR_ILIM, FULL, 32'h0A, 1, "detected limit");
		poll(ADDR_CONFIG, 32'h1FF00, 32'h0A00, 1, "min clamp");
		$display("Test overvoltage done");
		sense.busUvloOk <= 1'b0;
		repeat (4) @(posedge clk);
		chkPin("battery switch", 1'b1, batterySwitchOn);
		poll(ADDR_STATUS, 32'h85, 32'h0, 1, "bus lost");
		chkPin("pair gate off", 1'b0, pairGateOn);
		sense.directPath <= 1'b0;
		sense.auxPresent <= 1'b1;
		repeat (2) @(posedge clk);
		chkPin("aux gate", 1'b1, pairGateOn);
		sense.directPath <= 1'b1;
		sense.auxPresent <= 1'b0;
		for (int k = 0; k < 6; k++)
		begin
			wr(ADDR_CTRL, {25'h0, ctlTab[k]});
			sense.batAbove3v2 <= b32Bits[k];
			repeat (4) @(posedge clk);
			chkPin("battery bias", biasBits[k], biasOn);
		end
		$display("Test battery done");
		wr(ADDR_MASK, 32'h1);
		wr(ADDR_FLAG, 32'h7);
		n0 = alertPulses;
		sense.busPoor <= 1'b1;
		@(posedge clk);
		sense.busUvloOk <= 1'b1;
		poll(ADDR_CTRL, 32'h1, 32'h1, 2000, "poor hiz");
		poll(ADDR_FLAG, 32'h1, 32'h1, 1, "poor flag");
		poll(ADDR_STATUS, 32'h4, 32'h0, 1, "no good");
		wr(ADDR_FLAG, 32'h7);
		poll(ADDR_FLAG, 32'h1, 32'h1, 2000, "retry flag");
		chk("masked alert", {24'h0, n0}, {24'h0, alertPulses});
		sense.busUvloOk <= 1'b0;
		repeat (4) @(posedge clk);
		sense.busUvloOk <= 1'b1;
		repeat (4) @(posedge clk);
		poll(ADDR_CTRL, 32'h1, 32'h0, 1, "insert clears");
		poll(ADDR_CTRL, 32'h1, 32'h1, 2000, "fails again");
		sense.busPoor <= 1'b0;
		wr(ADDR_CTRL, 32'h26);
		poll(ADDR_STATUS, 32'h4, 32'h4, 300, "host retry");
		$display("Test poor source done");
		completeRun();
	end
endmodule
